// File: design/fpm_counters.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Receive performance-monitor counters read over the processor port
// Assumes: Event inputs are one-cycle pulses from logic on ref_clk
// Notes:   Read data is registered; one read per strobe
//////////////////////////////////////////////////////////////////////////////
`default_nettype none

module fpm_counters
    import fpm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Processor read port
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_addr,
    output logic [7:0] cpu_rd_data,
    output logic cpu_rd_valid,
    // Control levels
    input wire logic one_second_latch_enable,
    input wire logic one_second_latch_clear,
    input wire logic excess_zero_include_enable,
    input wire logic test_pattern_start,
    input wire logic [FPM_OV_N-1:0] counter_overflow_irq_enable,
    // Framer status and events
    input wire logic frame_loss_indicator,
    input wire logic [1:0] align_loss_reason,
    input wire logic framing_bit_err,
    input wire logic crc_block_err,
    input wire logic bipolar_violation,
    input wire logic excess_zero_event,
    input wire logic far_block_err,
    input wire logic prbs_bit_err,
    input wire logic reframe_pulse,
    input wire logic severe_frame_alarm,
    // Status outputs
    output fpm_cause_t align_loss_cause,
    output logic [FPM_OV_N-1:0] counter_overflow
);

    //////////////////////////////////////////////////////////////////////////
    // Step helper shared by every counter
    //////////////////////////////////////////////////////////////////////////

    // Clear and increment in one cycle leaves a count of one
    function automatic logic [15:0] cnt_step(
        input logic [15:0] cnt,
        input logic [15:0] maxv,
        input logic inc,
        input logic clr,
        input logic wrap
    );
        logic [15:0] base;
        base = clr ? FPM_COUNT_RST : cnt;
        if (!inc) begin
            cnt_step = base;
        end else if (base == maxv) begin
            cnt_step = wrap ? FPM_COUNT_RST : maxv;
        end else begin
            cnt_step = base + 16'h0001;
        end
    endfunction

    function automatic logic cnt_full(
        input logic [15:0] cnt,
        input logic [15:0] maxv,
        input logic inc,
        input logic clr
    );
        cnt_full = inc && !clr && (cnt == maxv);
    endfunction

    // Largest value of each count, from its width
    localparam logic [15:0] MAX_FRAMING = 16'((32'h1 << FPM_FRAMING_W) - 32'h1);
    localparam logic [15:0] MAX_CRC = 16'((32'h1 << FPM_CRC_W) - 32'h1);
    localparam logic [15:0] MAX_LCV = 16'((32'h1 << FPM_LCV_W) - 32'h1);
    localparam logic [15:0] MAX_FAR_BLOCK_ERR_COUNT_HI = 16'((32'h1 << FPM_FAR_BLOCK_ERR_COUNT_HI_W) - 32'h1);
    localparam logic [15:0] MAX_PRBS = 16'((32'h1 << FPM_PRBS_W) - 32'h1);
    localparam logic [15:0] MAX_FLOSS = 16'((32'h1 << FPM_FLOSS_W) - 32'h1);
    localparam logic [15:0] MAX_ALIGN_CHANGE_COUNT = 16'((32'h1 << FPM_ALIGN_CHANGE_COUNT_W) - 32'h1);
    localparam logic [15:0] MAX_SEF = 16'((32'h1 << FPM_SEF_W) - 32'h1);

    //////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    //////////////////////////////////////////////////////////////////////////

    // Every count must fit the 16-bit step helper
    if (FPM_FRAMING_W > 16 || FPM_CRC_W > 16 || FPM_LCV_W > 16
        || FPM_FAR_BLOCK_ERR_COUNT_HI_W > 16 || FPM_PRBS_W > 16) begin : g_width_check
        $error("count wider than the 16-bit step helper");
    end

    // The three alarm fields must tile the alarm byte exactly
    if (FPM_ALARM_EVENT_COUNT_SEF_LSB != 0
        || FPM_ALARM_EVENT_COUNT_ALIGN_CHANGE_COUNT_LSB != FPM_ALARM_EVENT_COUNT_SEF_LSB + FPM_SEF_W
        || FPM_ALARM_EVENT_COUNT_FLOSS_LSB != FPM_ALARM_EVENT_COUNT_ALIGN_CHANGE_COUNT_LSB + FPM_ALIGN_CHANGE_COUNT_W
        || FPM_ALARM_EVENT_COUNT_FLOSS_LSB + FPM_FLOSS_W != 8) begin : g_alarm_check
        $error("alarm fields do not fill one byte");
    end

    // One overflow enable and flag per counter
    if (FPM_OV_N != 8 || FPM_OV_SEF != FPM_OV_N - 1) begin : g_ov_check
        $error("overflow bit map does not cover eight counters");
    end

    //////////////////////////////////////////////////////////////////////////
    // Read decode
    //////////////////////////////////////////////////////////////////////////

    logic rd_framing_lo, rd_framing_hi, rd_crc_lo, rd_crc_hi;
    logic rd_lcv_lo, rd_lcv_hi, rd_far_block_err_count_hi_lo, rd_far_block_err_count_hi_hi;
    logic rd_prbs_lo, rd_prbs_hi, rd_alarm;
    logic clr_ok;

    assign rd_framing_lo = cpu_rd && (cpu_addr == FPM_FRAMING_ERR_COUNT_LO);
    assign rd_framing_hi = cpu_rd && (cpu_addr == FPM_FRAMING_ERR_COUNT_HI);
    assign rd_crc_lo = cpu_rd && (cpu_addr == FPM_CRC_ERR_COUNT_LO);
    assign rd_crc_hi = cpu_rd && (cpu_addr == FPM_CRC_ERR_COUNT_HI);
    assign rd_lcv_lo = cpu_rd && (cpu_addr == FPM_LINE_VIOLATION_COUNT_LO);
    assign rd_lcv_hi = cpu_rd && (cpu_addr == FPM_LINE_VIOLATION_COUNT_HI);
    assign rd_far_block_err_count_hi_lo = cpu_rd && (cpu_addr == FPM_FAR_BLOCK_ERR_COUNT_LO);
    assign rd_far_block_err_count_hi_hi = cpu_rd && (cpu_addr == FPM_FAR_BLOCK_ERR_COUNT_HI);
    assign rd_prbs_lo = cpu_rd && (cpu_addr == FPM_PRBS_ERR_COUNT_LO);
    assign rd_prbs_hi = cpu_rd && (cpu_addr == FPM_PRBS_ERR_COUNT_HI);
    assign rd_alarm = cpu_rd && (cpu_addr == FPM_ALARM_EVENT_COUNT);

    // Framing, CRC and violation high reads and far-end reads clear only outside latched mode; PRBS low and alarm reads always clear
    assign clr_ok = !one_second_latch_enable;

    //////////////////////////////////////////////////////////////////////////
    // Counter state
    //////////////////////////////////////////////////////////////////////////

    logic [15:0] framing_reg, crc_reg, lcv_reg, far_block_err_count_hi_reg, prbs_live_reg;
    logic [15:0] floss_reg, align_change_count_reg, sef_reg;
    logic [15:0] framing_next, crc_next, lcv_next, far_block_err_count_hi_next, prbs_next;
    logic [15:0] floss_next, align_change_count_next, sef_next;
    logic clr_framing, clr_crc, clr_lcv, clr_far_block_err_count_hi, clr_prbs, clr_alarm;
    logic inc_lcv, inc_prbs, loss_edge;
    logic [FPM_OV_N-1:0] ov;
    logic fli_prev_reg;

    assign loss_edge = frame_loss_indicator && !fli_prev_reg;
    assign inc_lcv = bipolar_violation || (excess_zero_include_enable && excess_zero_event);
    assign inc_prbs = prbs_bit_err && test_pattern_start;

    assign clr_framing = (rd_framing_hi && clr_ok) || one_second_latch_clear;
    assign clr_crc = (rd_crc_hi && clr_ok) || one_second_latch_clear;
    assign clr_lcv = (rd_lcv_hi && clr_ok) || one_second_latch_clear;
    assign clr_far_block_err_count_hi = ((rd_far_block_err_count_hi_lo || rd_far_block_err_count_hi_hi) && clr_ok) || one_second_latch_clear;
    assign clr_prbs = rd_prbs_lo;
    assign clr_alarm = rd_alarm;

    assign framing_next = cnt_step(framing_reg, MAX_FRAMING, framing_bit_err, clr_framing,
        counter_overflow_irq_enable[FPM_OV_FRAMING]);
    assign crc_next = cnt_step(crc_reg, MAX_CRC, crc_block_err, clr_crc,
        counter_overflow_irq_enable[FPM_OV_CRC]);
    assign lcv_next = cnt_step(lcv_reg, MAX_LCV, inc_lcv, clr_lcv,
        counter_overflow_irq_enable[FPM_OV_LCV]);
    assign far_block_err_count_hi_next = cnt_step(far_block_err_count_hi_reg, MAX_FAR_BLOCK_ERR_COUNT_HI, far_block_err, clr_far_block_err_count_hi,
        counter_overflow_irq_enable[FPM_OV_FAR_BLOCK_ERR_COUNT_HI]);
    assign prbs_next = cnt_step(prbs_live_reg, MAX_PRBS, inc_prbs, clr_prbs,
        counter_overflow_irq_enable[FPM_OV_PRBS]);
    assign floss_next = cnt_step(floss_reg, MAX_FLOSS, loss_edge, clr_alarm,
        counter_overflow_irq_enable[FPM_OV_FLOSS]);
    assign align_change_count_next = cnt_step(align_change_count_reg, MAX_ALIGN_CHANGE_COUNT, reframe_pulse, clr_alarm,
        counter_overflow_irq_enable[FPM_OV_ALIGN_CHANGE_COUNT]);
    assign sef_next = cnt_step(sef_reg, MAX_SEF, severe_frame_alarm, clr_alarm,
        counter_overflow_irq_enable[FPM_OV_SEF]);

    assign ov[FPM_OV_FRAMING] = cnt_full(framing_reg, MAX_FRAMING, framing_bit_err, clr_framing);
    assign ov[FPM_OV_CRC] = cnt_full(crc_reg, MAX_CRC, crc_block_err, clr_crc);
    assign ov[FPM_OV_LCV] = cnt_full(lcv_reg, MAX_LCV, inc_lcv, clr_lcv);
    assign ov[FPM_OV_FAR_BLOCK_ERR_COUNT_HI] = cnt_full(far_block_err_count_hi_reg, MAX_FAR_BLOCK_ERR_COUNT_HI, far_block_err, clr_far_block_err_count_hi);
    assign ov[FPM_OV_PRBS] = cnt_full(prbs_live_reg, MAX_PRBS, inc_prbs, clr_prbs);
    assign ov[FPM_OV_FLOSS] = cnt_full(floss_reg, MAX_FLOSS, loss_edge, clr_alarm);
    assign ov[FPM_OV_ALIGN_CHANGE_COUNT] = cnt_full(align_change_count_reg, MAX_ALIGN_CHANGE_COUNT, reframe_pulse, clr_alarm);
    assign ov[FPM_OV_SEF] = cnt_full(sef_reg, MAX_SEF, severe_frame_alarm, clr_alarm);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            framing_reg <= FPM_COUNT_RST;
            crc_reg <= FPM_COUNT_RST;
            lcv_reg <= FPM_COUNT_RST;
            far_block_err_count_hi_reg <= FPM_COUNT_RST;
            prbs_live_reg <= FPM_COUNT_RST;
            floss_reg <= FPM_COUNT_RST;
            align_change_count_reg <= FPM_COUNT_RST;
            sef_reg <= FPM_COUNT_RST;
        end else begin
            framing_reg <= framing_next;
            crc_reg <= crc_next;
            lcv_reg <= lcv_next;
            far_block_err_count_hi_reg <= far_block_err_count_hi_next;
            prbs_live_reg <= prbs_next;
            floss_reg <= floss_next;
            align_change_count_reg <= align_change_count_next;
            sef_reg <= sef_next;
        end
    end

    // Overflow flags pulse for one cycle when a counter passes its maximum
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            counter_overflow <= '0;
        end else begin
            counter_overflow <= ov & counter_overflow_irq_enable;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Loss cause capture
    //////////////////////////////////////////////////////////////////////////

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fli_prev_reg <= 1'b0;
            align_loss_cause <= FPM_CAUSE_FAS;
        end else begin
            fli_prev_reg <= frame_loss_indicator;
            if (loss_edge) begin
                align_loss_cause <= fpm_cause_t'(align_loss_reason);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // High-byte snapshots taken at low-byte reads
    //////////////////////////////////////////////////////////////////////////

    logic [7:0] framing_hi_reg, crc_hi_reg, lcv_hi_reg, far_block_err_count_hi_hi_reg;
    logic [FPM_PRBS_W-1:0] prbs_report_reg;

    // Low-then-high reads see one coherent count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            framing_hi_reg <= FPM_BYTE_RST;
            crc_hi_reg <= FPM_BYTE_RST;
            lcv_hi_reg <= FPM_BYTE_RST;
            far_block_err_count_hi_hi_reg <= FPM_BYTE_RST;
        end else begin
            if (rd_framing_lo) begin
                framing_hi_reg <= {4'h0, framing_reg[11:8]};
            end
            if (rd_crc_lo) begin
                crc_hi_reg <= {6'h00, crc_reg[9:8]};
            end
            if (rd_lcv_lo) begin
                lcv_hi_reg <= lcv_reg[15:8];
            end
            if (rd_far_block_err_count_hi_lo) begin
                far_block_err_count_hi_hi_reg <= {6'h00, far_block_err_count_hi_reg[9:8]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prbs_report_reg <= '0;
        end else if (rd_prbs_lo) begin
            prbs_report_reg <= prbs_live_reg[FPM_PRBS_W-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data
    //////////////////////////////////////////////////////////////////////////

    logic [7:0] alarm_byte;
    logic [7:0] rd_mux;

    // Fields placed by the package positions
    always_comb begin
        alarm_byte = FPM_BYTE_RST;
        alarm_byte[FPM_ALARM_EVENT_COUNT_FLOSS_LSB +: FPM_FLOSS_W] = floss_reg[FPM_FLOSS_W-1:0];
        alarm_byte[FPM_ALARM_EVENT_COUNT_ALIGN_CHANGE_COUNT_LSB +: FPM_ALIGN_CHANGE_COUNT_W] = align_change_count_reg[FPM_ALIGN_CHANGE_COUNT_W-1:0];
        alarm_byte[FPM_ALARM_EVENT_COUNT_SEF_LSB +: FPM_SEF_W] = sef_reg[FPM_SEF_W-1:0];
    end

    always_comb begin
        rd_mux = FPM_BYTE_RST;
        unique case (cpu_addr)
            FPM_FRAMING_ERR_COUNT_LO: rd_mux = framing_reg[7:0];
            FPM_FRAMING_ERR_COUNT_HI: rd_mux = framing_hi_reg;
            FPM_CRC_ERR_COUNT_LO: rd_mux = crc_reg[7:0];
            FPM_CRC_ERR_COUNT_HI: rd_mux = crc_hi_reg;
            FPM_LINE_VIOLATION_COUNT_LO: rd_mux = lcv_reg[7:0];
            FPM_LINE_VIOLATION_COUNT_HI: rd_mux = lcv_hi_reg;
            FPM_FAR_BLOCK_ERR_COUNT_LO: rd_mux = far_block_err_count_hi_reg[7:0];
            FPM_FAR_BLOCK_ERR_COUNT_HI: rd_mux = far_block_err_count_hi_hi_reg;
            FPM_PRBS_ERR_COUNT_LO: rd_mux = prbs_live_reg[7:0];
            FPM_PRBS_ERR_COUNT_HI: rd_mux = {4'h0, prbs_report_reg[11:8]};
            FPM_ALARM_EVENT_COUNT: rd_mux = alarm_byte;
            default: rd_mux = FPM_BYTE_RST;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_rd_data <= FPM_BYTE_RST;
            cpu_rd_valid <= 1'b0;
        end else begin
            cpu_rd_valid <= cpu_rd;
            if (cpu_rd) begin
                cpu_rd_data <= rd_mux;
            end
        end
    end

endmodule

`default_nettype wire

// File: design/fpm_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the framer performance-monitor counter block
// Assumes: Byte-wide processor reads, one reference clock
// Notes:   Summary of the block's behaviour follows
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Capture two-bit loss cause on each new loss; hold until next loss.
// - Cause codes: 00 FAS, 01 NFAS, 10 CRC-4 threshold, 11 8 ms MFAS timeout.
// - Counter with overflow interrupt enabled wraps to zero after maximum.
// - Counter with overflow interrupt disabled sticks at its maximum value.
// - 12-bit framing error count; high-byte read clears it unless latched.
// - 10-bit CRC block error count; high-byte read clears it unless latched.
// - 16-bit violation count, excess zeros when enabled; high read clears unless latched.
// - 10-bit far-end block error count, E1 only; read clears unless latched.
// - PRBS low read copies live 12-bit count to report, then clears live.
// - PRBS high read returns upper four bits captured at last low read.
// - PRBS error counting suspended while test pattern start is zero.
// - Alarm byte packs loss 7:4, change 3:2, severe 1:0; any read clears.
// - Four-bit frame-loss count increments on each new loss indication.
// - Two-bit alignment-change count increments on each reframe pulse.
// - Two-bit severe frame count increments on each severe frame alarm.
// - Frame-loss indicator is a live level: one lost, zero recovered.
//////////////////////////////////////////////////////////////////////////////
`default_nettype none

package fpm_pkg;

    // Register offsets
    localparam logic [7:0] FPM_FRAMING_ERR_COUNT_LO = 8'h50;
    localparam logic [7:0] FPM_FRAMING_ERR_COUNT_HI = 8'h51;
    localparam logic [7:0] FPM_CRC_ERR_COUNT_LO = 8'h52;
    localparam logic [7:0] FPM_CRC_ERR_COUNT_HI = 8'h53;
    localparam logic [7:0] FPM_LINE_VIOLATION_COUNT_LO = 8'h54;
    localparam logic [7:0] FPM_LINE_VIOLATION_COUNT_HI = 8'h55;
    localparam logic [7:0] FPM_FAR_BLOCK_ERR_COUNT_LO = 8'h56;
    localparam logic [7:0] FPM_FAR_BLOCK_ERR_COUNT_HI = 8'h57;
    localparam logic [7:0] FPM_PRBS_ERR_COUNT_LO = 8'h58;
    localparam logic [7:0] FPM_PRBS_ERR_COUNT_HI = 8'h59;
    localparam logic [7:0] FPM_ALARM_EVENT_COUNT = 8'h5A;

    // Counter widths
    localparam int FPM_FRAMING_W = 12;
    localparam int FPM_CRC_W = 10;
    localparam int FPM_LCV_W = 16;
    localparam int FPM_FAR_BLOCK_ERR_COUNT_HI_W = 10;
    localparam int FPM_PRBS_W = 12;
    localparam int FPM_FLOSS_W = 4;
    localparam int FPM_ALIGN_CHANGE_COUNT_W = 2;
    localparam int FPM_SEF_W = 2;

    // Alarm byte field positions
    localparam int FPM_ALARM_EVENT_COUNT_FLOSS_LSB = 4;
    localparam int FPM_ALARM_EVENT_COUNT_ALIGN_CHANGE_COUNT_LSB = 2;
    localparam int FPM_ALARM_EVENT_COUNT_SEF_LSB = 0;

    // Overflow enable / overflow flag bit positions
    localparam int FPM_OV_FRAMING = 0;
    localparam int FPM_OV_CRC = 1;
    localparam int FPM_OV_LCV = 2;
    localparam int FPM_OV_FAR_BLOCK_ERR_COUNT_HI = 3;
    localparam int FPM_OV_PRBS = 4;
    localparam int FPM_OV_FLOSS = 5;
    localparam int FPM_OV_ALIGN_CHANGE_COUNT = 6;
    localparam int FPM_OV_SEF = 7;
    localparam int FPM_OV_N = 8;

    // Reset values
    localparam logic [15:0] FPM_COUNT_RST = 16'h0000;
    localparam logic [7:0] FPM_BYTE_RST = 8'h00;

    // Loss-of-alignment cause codes
    typedef enum logic [1:0] {
        FPM_CAUSE_FAS = 2'h0,
        FPM_CAUSE_NFAS = 2'h1,
        FPM_CAUSE_CRC4 = 2'h2,
        FPM_CAUSE_MFAS_TMO = 2'h3
    } fpm_cause_t;

endpackage

`default_nettype wire

// File: testbench/fpm_counters_monitor.sv
// Purpose: Port checker for fpm_counters
// Assumes: One clock, rst synchronous high
// Notes:   Attached by bind below
`default_nettype none
module fpm_counters_monitor
    import fpm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Read port
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_rd_data,
    // Controls and events
    input wire logic one_second_latch_enable,
    input wire logic test_pattern_start,
    input wire logic [FPM_OV_N-1:0] counter_overflow_irq_enable,
    input wire logic frame_loss_indicator,
    input wire logic [1:0] align_loss_reason,
    input wire logic framing_bit_err,
    input wire logic reframe_pulse,
    input wire logic severe_frame_alarm,
    // Status
    input wire fpm_cause_t align_loss_cause,
    input wire logic [FPM_OV_N-1:0] counter_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic ind_reg;
    logic new_loss;
    logic quiet;
    logic rd_alm;
    logic rd_prbs;
    always_ff @(posedge ref_clk) begin
        ind_reg <= rst ? 1'b0 : frame_loss_indicator;
    end
    assign new_loss = frame_loss_indicator && !ind_reg;
    assign quiet = !new_loss && !reframe_pulse && !severe_frame_alarm;
    assign rd_alm = cpu_rd && cpu_addr == FPM_ALARM_EVENT_COUNT;
    assign rd_prbs = cpu_rd && cpu_addr == FPM_PRBS_ERR_COUNT_LO;
    sequence s_alm_clr;
        rd_alm && quiet ##1 quiet;
    endsequence
    sequence s_prbs_clr;
        rd_prbs && !test_pattern_start ##1 !test_pattern_start;
    endsequence
    sequence s_fe_clr;
        cpu_rd && cpu_addr == FPM_FRAMING_ERR_COUNT_HI && !one_second_latch_enable
            && !framing_bit_err ##1 !framing_bit_err;
    endsequence
    AST_CAUSE_CAPT: assert property (new_loss |=> align_loss_cause == $past(align_loss_reason))
        else $error("loss cause not captured");
    AST_CAUSE_HOLD: assert property (!new_loss |=> $stable(align_loss_cause))
        else $error("loss cause changed without new loss");
    AST_UPPER_ZERO: assert property (cpu_rd && cpu_addr inside {8'h51, 8'h53, 8'h57, 8'h59}
        |=> (cpu_rd_data & ($past(cpu_addr) inside {8'h51, 8'h59} ? 8'hF0 : 8'hFC)) == 8'h00)
        else $error("unused high bits not zero");
    AST_FE_CLR: assert property (s_fe_clr ##1 (cpu_rd && cpu_addr == 8'h50)
        |=> cpu_rd_data == 8'h00) else $error("framing count not cleared");
    AST_PRBS_CLR: assert property (s_prbs_clr ##1 rd_prbs |=> cpu_rd_data == 8'h00)
        else $error("live prbs count not cleared");
    AST_ALM_CLR: assert property (s_alm_clr ##1 rd_alm |=> cpu_rd_data == 8'h00)
        else $error("alarm counts not cleared");
    AST_OVF_EN: assert property ((counter_overflow & ~$past(counter_overflow_irq_enable)) == '0)
        else $error("overflow on a saturating counter");
    AST_ALIGN_CHANGE_COUNT_GAP: assert property (counter_overflow[FPM_OV_ALIGN_CHANGE_COUNT]
        |=> !counter_overflow[FPM_OV_ALIGN_CHANGE_COUNT] [*3]) else $error("align change wrap too soon");
endmodule
bind fpm_counters fpm_counters_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_rd_data(cpu_rd_data),
    .one_second_latch_enable(one_second_latch_enable), .test_pattern_start(test_pattern_start),
    .counter_overflow_irq_enable(counter_overflow_irq_enable),
    .frame_loss_indicator(frame_loss_indicator), .align_loss_reason(align_loss_reason),
    .framing_bit_err(framing_bit_err), .reframe_pulse(reframe_pulse),
    .severe_frame_alarm(severe_frame_alarm), .align_loss_cause(align_loss_cause),
    .counter_overflow(counter_overflow));
`default_nettype wire

// File: testbench/fpm_counters_tb.sv
// Purpose: Self-checking bench for fpm_counters
// Assumes: Host model reads; bench drives events on falling edges
// Notes:   Expected bytes queued, compared when valid appears
`default_nettype none
module fpm_counters_tb
    import fpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] AD [4] = '{8'h50, 8'h52, 8'h54, 8'h56};
    localparam int EVI [4] = '{0, 1, 2, 4};
    logic ref_clk;
    logic rst;
    logic cpu_rd;
    logic [7:0] cpu_addr;
    logic [7:0] cpu_rd_data;
    logic cpu_rd_valid;
    logic latch_en;
    logic exz_en;
    logic tps;
    logic ind;
    logic [1:0] reason;
    logic [8:0] ev;
    logic [FPM_OV_N-1:0] ov_en;
    logic [FPM_OV_N-1:0] ovf;
    fpm_cause_t cause;
    logic mfas_seen;
    logic [15:0] exp_q [$];
    int n_mismatch;
    int tests_run;
    int align_change_count_ovf;
    fpm_counters u_dut (.ref_clk(ref_clk), .rst(rst), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid), .one_second_latch_enable(latch_en),
        .one_second_latch_clear(ev[8]), .excess_zero_include_enable(exz_en),
        .test_pattern_start(tps), .counter_overflow_irq_enable(ov_en),
        .frame_loss_indicator(ind), .align_loss_reason(reason), .framing_bit_err(ev[0]),
        .crc_block_err(ev[1]), .bipolar_violation(ev[2]), .excess_zero_event(ev[3]),
        .far_block_err(ev[4]), .prbs_bit_err(ev[5]), .reframe_pulse(ev[6]),
        .severe_frame_alarm(ev[7]), .align_loss_cause(cause), .counter_overflow(ovf));
    fpm_host u_host (.ref_clk(ref_clk), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .counter_overflow(ovf), .mfas_timeout_seen(mfas_seen));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Oldest note matched against each returned byte
    always @(negedge ref_clk) begin
        if (cpu_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unrequested read", 8'h00, cpu_rd_data);
            end else begin
                chk($sformatf("reg %h", exp_q[0][15:8]), exp_q[0][7:0], cpu_rd_data);
                void'(exp_q.pop_front());
            end
        end
        if (ovf[FPM_OV_ALIGN_CHANGE_COUNT] === 1'b1) align_change_count_ovf++;
    end
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        u_host.rd(a);
    endtask
    task automatic rdp(input logic [7:0] lo, input logic [15:0] v);
        exp_q.push_back({lo, v[7:0]});
        exp_q.push_back({lo + 8'h01, v[15:8]});
        u_host.rd_pair(lo);
    endtask
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(negedge ref_clk) ev[i] = 1'b1;
            @(negedge ref_clk) ev[i] = 1'b0;
        end
    endtask
    task automatic loss(input logic [1:0] c);
        @(negedge ref_clk);
        reason = c;
        ind = 1'b1;
        @(negedge ref_clk);
        ind = 1'b0;
        reason = ~c;
    endtask
    initial begin
        #(20000 * 100);
        n_mismatch++;
        final_report();
    end
    initial begin
        int n;
        {rst, latch_en, exz_en, tps, ind, reason, ev, ov_en} = '0;
        rst = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        align_change_count_ovf = 0;
        void'($urandom(79948));
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 8'h50; a <= 8'h5A; a++) rdc(8'(a), 8'h00);
        rdc(8'h60, 8'h00);
        $display("Test reset values done");
        for (int i = 0; i < 4; i++) begin
            n = $urandom_range(400, 256);
            pulse(EVI[i], n);
            rdp(AD[i], 16'(n));
            rdc(AD[i], 8'h00);
        end
        pulse(3, 3);
        exz_en = 1'b1;
        pulse(3, 2);
        pulse(2, 1);
        rdp(8'h54, 16'h0003);
        $display("Test error counters done");
        latch_en = 1'b1;
        pulse(0, 5);
        rdp(8'h50, 16'h0005);
        rdc(8'h50, 8'h05);
        pulse(8, 1);
        rdc(8'h50, 8'h00);
        latch_en = 1'b0;
        $display("Test latched mode done");
        pulse(6, 5);
        pulse(7, 2);
        rdc(8'h5A, 8'h0E);
        rdc(8'h5A, 8'h00);
        ov_en = 8'hFF;
        pulse(6, 5);
        rdc(8'h5A, 8'h04);
        chk("align change wraps", 8'h01, 8'(align_change_count_ovf));
        $display("Test alarm counts done");
        pulse(5, 4);
        tps = 1'b1;
        n = $urandom_range(300, 256);
        pulse(5, n);
        rdc(8'h58, 8'(n));
        pulse(5, 3);
        tps = 1'b0;
        pulse(5, 2);
        rdc(8'h59, 8'(n >> 8));
        rdc(8'h58, 8'h03);
        rdc(8'h58, 8'h00);
        rdc(8'h59, 8'h00);
        $display("Test prbs count done");
        for (int c = 0; c < 4; c++) begin
            loss(2'(c));
            repeat (3) @(negedge ref_clk);
            chk("loss cause", 8'(c), 8'(cause));
        end
        rdc(8'h5A, 8'h40);
        repeat (16) loss(2'($urandom_range(3, 0)));
        rdc(8'h5A, 8'h00);
        chk("search timeout", 8'h01, 8'(mfas_seen));
        $display("Test frame loss done");
        repeat (4) @(negedge ref_clk);
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        final_report();
    end
endmodule
`default_nettype wire

// File: testbench/fpm_host.sv
// Purpose: Host processor model issuing byte reads
// Assumes: Strobe launched on the falling edge, one cycle long
// Notes:   Frame-loss wrap is taken as a search timeout
`default_nettype none
module fpm_host
    import fpm_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Read port
    output logic cpu_rd,
    output logic [7:0] cpu_addr,
    // Status
    input wire logic [FPM_OV_N-1:0] counter_overflow,
    output logic mfas_timeout_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cpu_rd = 1'b0;
        cpu_addr = 8'h00;
    end
    // Frame-loss wrap flags a timed-out search
    initial begin
        mfas_timeout_seen = 1'b0;
        forever begin
            @(negedge ref_clk);
            if (counter_overflow[FPM_OV_FLOSS] === 1'b1) mfas_timeout_seen = 1'b1;
        end
    end
    // Released address shows its inverse
    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        cpu_rd = 1'b1;
        cpu_addr = a;
        @(negedge ref_clk);
        cpu_rd = 1'b0;
        cpu_addr = ~a;
    endtask
    task automatic rd_pair(input logic [7:0] lo);
        rd(lo);
        rd(lo + 8'h01);
    endtask
endmodule
`default_nettype wire
